/* src/chgctl_top.sv */
// Contract
// - Reset input limit is 100 mA
// - Changed field overrides the select pin
// - Pin low 100 mA, high 500 mA
// - Field offers 100..1500 mA steps
// - Flag when limit throttles charge current
// - Below dead threshold: trickle, report state
// - Trickle: isolation off, rail at trickle voltage
// - Trickle over 60 minutes: stop, fault
// - Between thresholds: weak charge mode
// - Weak mode input limit stays 100 mA
// - Weak mode 20 mA through trickle branch
// - Weak: isolation switch regulates charge voltage
// - Enable low disables all charging modes
// - Above weak: fast charge, code 010
//
// Added by the designer: the register offsets and register access over AHB-Lite.
module chgctl_top
	import chgctl_pkg::*;
#(
	parameter int unsigned CLK_HZ      = CTL_CLK_HZ,
	parameter int unsigned TRICKLE_SEC = CTL_TRICKLE_SEC
)
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic [31:0]      hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	// Pins and comparators
	input  wire logic        limit_select_pin_in,
	input  wire logic        pin_role_in,
	input  wire logic        supply_ok_in,
	input  wire logic        above_dead_in,
	input  wire logic        above_weak_in,
	input  wire logic        limit_active_in,
	// Charger drive
	output chgctl_drive_type drive_out,
	output logic [2:0]       charge_state_out,
	output logic             input_limited_flag_out
);

	// ==========================================================
	// State machine
	// ==========================================================
	typedef enum logic [4:0] {
		CS_IDLE    = 5'b00001,
		CS_TRICKLE = 5'b00010,
		CS_WEAK    = 5'b00100,
		CS_FAST    = 5'b01000,
		CS_FAULT   = 5'b10000
	} chgctl_state_type;

	chgctl_state_type state_q;       // Charge phase
	chgctl_state_type state_d;       // Next phase

	// ==========================================================
	// Registers
	// ==========================================================
	logic [3:0]  limit_field_q;      // input_limit_field
	logic        field_changed_q;    // Host moved the field off default
	logic        charge_enable_q;    // charge_enable_bit
	logic [11:0] fast_ma_q;          // fast_charge_current
	logic        fault_clear;        // Host write that clears a fault
	logic        limited_q;          // input_limited_flag
	logic [11:0] limit_ma;           // Active limit from resolver

	// ==========================================================
	// Trickle timer
	// ==========================================================
	localparam int unsigned TICK_MAX = CLK_HZ - 1;
	logic [31:0] tick_q;             // Cycles within one second
	logic [15:0] sec_q;              // Seconds in trickle
	logic        timeout;            // Trickle exceeded its window

	// ==========================================================
	// Bus address phase capture
	// ==========================================================
	logic        wr_q;               // Pending write
	logic        rd_q;               // Pending read
	logic [7:0]  addr_q;             // Captured offset
	logic        take;               // Transfer accepted

	assign take          = hsel_in & hready_in & htrans_in[1];
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// Capture the address phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q   <= take & hwrite_in;
			rd_q   <= take & ~hwrite_in;
			addr_q <= haddr_in[7:0];
		end
	end

	// Register writes in the data phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			limit_field_q   <= CTL_LIM_RST;
			field_changed_q <= 1'b0;
			charge_enable_q <= 1'b1;
			fast_ma_q       <= CTL_FAST_RST_MA;
		end else if (wr_q) begin
			if (addr_q == CTL_ADDR_LIMIT) begin
				// Codes beyond the table clamp to the top step
				limit_field_q <= (hwdata_in[3:0] > CTL_LIM_MAX) ?
					CTL_LIM_MAX : hwdata_in[3:0];
				if (hwdata_in[3:0] != CTL_LIM_RST) begin
					field_changed_q <= 1'b1;
				end
			end else if (addr_q == CTL_ADDR_CONTROL) begin
				charge_enable_q <= hwdata_in[0];
				fast_ma_q       <= hwdata_in[27:16];
			end
		end
	end

	// A control write with enable low clears a latched fault
	assign fault_clear = wr_q & (addr_q == CTL_ADDR_CONTROL) & ~hwdata_in[0];

	// Read data, registered
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (take & ~hwrite_in) begin
			unique case (haddr_in[7:0])
				CTL_ADDR_LIMIT:   hrdata_out <= {27'h0, field_changed_q, limit_field_q};
				CTL_ADDR_CONTROL: hrdata_out <= {4'h0, fast_ma_q, 15'h0, charge_enable_q};
				CTL_ADDR_STATUS:  hrdata_out <= {4'h0, limit_ma, 11'h0,
					limited_q, 1'b0, charge_state_out};
				CTL_ADDR_TIMER:   hrdata_out <= {16'h0, sec_q};
				default:          hrdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Limit resolver
	// ==========================================================
	chgctl_limit u_limit (
		.clk_in              (clk_in),
		.rst_in              (rst_in),
		.field_in            (limit_field_q),
		.field_changed_in    (field_changed_q),
		.pin_role_in         (pin_role_in),
		.limit_select_pin_in (limit_select_pin_in),
		// Next phase, so the forced limit lands together with the weak code
		.weak_mode_in        (state_d == CS_WEAK),
		.limit_ma_out        (limit_ma)
	);

	// ==========================================================
	// Phase sequencing
	// ==========================================================
	assign timeout = (sec_q >= TRICKLE_SEC[15:0]);

	// Next phase from comparators and enable
	always_comb begin
		state_d = state_q;
		if (!charge_enable_q || !supply_ok_in) begin
			state_d = (state_q == CS_FAULT && charge_enable_q) ? CS_FAULT : CS_IDLE;
		end else begin
			unique case (state_q)
				CS_FAULT: state_d = CS_FAULT;
				CS_TRICKLE: begin
					if (above_weak_in) begin
						state_d = CS_FAST;
					end else if (above_dead_in) begin
						state_d = CS_WEAK;
					end else if (timeout) begin
						// A cell that reached the threshold in time is no fault
						state_d = CS_FAULT;
					end
				end
				default: begin
					if (above_weak_in) begin
						state_d = CS_FAST;
					end else if (above_dead_in) begin
						state_d = CS_WEAK;
					end else begin
						state_d = CS_TRICKLE;
					end
				end
			endcase
		end
		// Clear only a fault already held, so a fault raised this cycle wins
		if (fault_clear && state_q == CS_FAULT) begin
			state_d = CS_IDLE;
		end
	end

	// Phase register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= CS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Trickle timer: counts only inside trickle, zero elsewhere
	always_ff @(posedge clk_in) begin
		if (rst_in || state_q != CS_TRICKLE) begin
			tick_q <= 32'h0000_0000;
			sec_q  <= 16'h0000;
		end else if (tick_q == TICK_MAX) begin
			tick_q <= 32'h0000_0000;
			sec_q  <= timeout ? sec_q : sec_q + 16'h0001;
		end else begin
			tick_q <= tick_q + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Drive bundle per phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			drive_out        <= '0;
			charge_state_out <= CTL_ST_OFF;
		end else begin
			drive_out            <= '0;
			drive_out.limit_ma   <= limit_ma;
			unique case (state_d)
				CS_TRICKLE: begin
					drive_out.trickle_on     <= 1'b1;
					drive_out.sys_at_trickle <= 1'b1;
					charge_state_out         <= CTL_ST_TRICKLE;
				end
				CS_WEAK: begin
					drive_out.trickle_on    <= 1'b1;
					drive_out.current_ma    <= CTL_WEAK_MA;
					drive_out.iso_fet_on    <= 1'b1;
					drive_out.sys_at_charge <= 1'b1;
					charge_state_out        <= CTL_ST_WEAK;
				end
				CS_FAST: begin
					drive_out.fast_on       <= 1'b1;
					drive_out.current_ma    <= fast_ma_q;
					drive_out.iso_fet_on    <= 1'b1;
					drive_out.sys_at_charge <= 1'b1;
					charge_state_out        <= CTL_ST_FAST;
				end
				CS_FAULT: charge_state_out <= CTL_ST_FAULT;
				default:  charge_state_out <= CTL_ST_OFF;
			endcase
		end
	end

	// Limited flag: limit regulating while the fast or trickle branch is on
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			limited_q <= 1'b0;
		end else begin
			limited_q <= limit_active_in & (drive_out.fast_on | drive_out.trickle_on);
		end
	end

	assign input_limited_flag_out = limited_q;

endmodule

/* src/chgctl_pkg.sv */
package chgctl_pkg;

	// ==========================================================
	// Register map (byte addresses)
	// ==========================================================
	localparam logic [7:0] CTL_ADDR_LIMIT   = 8'h00;  // input_limit_field
	localparam logic [7:0] CTL_ADDR_CONTROL = 8'h04;  // charge_enable_bit and fast current
	localparam logic [7:0] CTL_ADDR_STATUS  = 8'h08;  // charge state, flags, effective limit
	localparam logic [7:0] CTL_ADDR_TIMER   = 8'h0c;  // trickle timer, seconds elapsed

	// ==========================================================
	// Input limit codes (4-bit field)
	// ==========================================================
	localparam logic [3:0] CTL_LIM_100  = 4'h0;
	localparam logic [3:0] CTL_LIM_150  = 4'h1;
	localparam logic [3:0] CTL_LIM_300  = 4'h2;
	localparam logic [3:0] CTL_LIM_500  = 4'h3;
	localparam logic [3:0] CTL_LIM_900  = 4'h4;
	localparam logic [3:0] CTL_LIM_1500 = 4'h5;
	localparam logic [3:0] CTL_LIM_MAX  = 4'h5;       // Highest legal code
	localparam logic [3:0] CTL_LIM_RST  = CTL_LIM_100;

	// ==========================================================
	// Charge state codes (3-bit)
	// ==========================================================
	localparam logic [2:0] CTL_ST_OFF     = 3'h0;
	localparam logic [2:0] CTL_ST_TRICKLE = 3'h1;
	localparam logic [2:0] CTL_ST_FAST    = 3'h2;
	localparam logic [2:0] CTL_ST_WEAK    = 3'h4;
	localparam logic [2:0] CTL_ST_FAULT   = 3'h6;

	// ==========================================================
	// Currents in mA
	// ==========================================================
	localparam logic [11:0] CTL_WEAK_MA     = 12'h014;  // 20 mA
	localparam logic [11:0] CTL_FAST_RST_MA = 12'h1f4;  // 500 mA default

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned CTL_CLK_HZ        = 125000000;
	localparam int unsigned CTL_TRICKLE_MIN   = 60;
	localparam int unsigned CTL_TRICKLE_SEC   = CTL_TRICKLE_MIN * 60;

	// ==========================================================
	// Control outputs travel together
	// ==========================================================
	typedef struct packed {
		logic        trickle_on;     // Revival current branch on
		logic        fast_on;        // Main charge branch on
		logic        iso_fet_on;     // Battery isolation switch conducting
		logic        sys_at_trickle; // Rail regulated to trickle_system_voltage
		logic        sys_at_charge;  // Rail regulated to charge_system_voltage
		logic [11:0] current_ma;     // Charge current target
		logic [11:0] limit_ma;       // Active input limit
	} chgctl_drive_type;

endpackage

/* src/chgctl_limit.sv */
// Resolves the active input limit from register, pin and mode
module chgctl_limit
	import chgctl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Sources
	input  wire logic [3:0]  field_in,
	input  wire logic        field_changed_in,
	input  wire logic        pin_role_in,
	input  wire logic        limit_select_pin_in,
	input  wire logic        weak_mode_in,
	// Result
	output logic [11:0]      limit_ma_out
);

	// ==========================================================
	// Code to mA lookup
	// ==========================================================
	function automatic logic [11:0] code_ma(input logic [3:0] code);
		logic [11:0] ma;
		ma = 12'h064;
		unique case (code)
			CTL_LIM_150:  ma = 12'h096;
			CTL_LIM_300:  ma = 12'h12c;
			CTL_LIM_500:  ma = 12'h1f4;
			CTL_LIM_900:  ma = 12'h384;
			CTL_LIM_1500: ma = 12'h5dc;
			default:      ma = 12'h064;
		endcase
		return ma;
	endfunction

	logic [3:0] code_d;  // Chosen code

	// Pick the code: weak mode and reset pin logic
	always_comb begin
		if (weak_mode_in) begin
			code_d = CTL_LIM_100;
		end else if (field_changed_in) begin
			code_d = field_in;
		end else if (pin_role_in) begin
			code_d = limit_select_pin_in ? CTL_LIM_500 : CTL_LIM_100;
		end else begin
			code_d = field_in;
		end
	end

	// Registered limit
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			limit_ma_out <= 12'h064;
		end else begin
			limit_ma_out <= code_ma(code_d);
		end
	end

endmodule

/* sim/chgctl_props.sv */
// Concurrent checks on the charger control ports
module chgctl_props
	import chgctl_pkg::*;
#(
	parameter int unsigned CLK_HZ      = 10,
	parameter int unsigned TRICKLE_SEC = 3
)
(
	// Clock and reset
	input wire logic             clk_in,
	input wire logic             rst_in,
	// Bus answer
	input wire logic             hreadyout_out,
	input wire logic             hresp_out,
	// Pins and comparators
	input wire logic             limit_select_pin_in,
	input wire logic             pin_role_in,
	input wire logic             supply_ok_in,
	input wire logic             above_dead_in,
	input wire logic             above_weak_in,
	// Charger drive
	input wire chgctl_drive_type drive_out,
	input wire logic [2:0]       charge_state_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Trickle cycle counter
	// ==========================================================
	localparam int unsigned LIM = CLK_HZ * TRICKLE_SEC;  // Trickle budget in cycles
	int unsigned cnt_q;                                  // Cycles spent in trickle
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Restarts whenever trickle is left
	always_ff @(posedge clk_in) begin
		if (rst_in || charge_state_out != CTL_ST_TRICKLE) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	// ==========================================================
	// Sequences and assertions
	// ==========================================================
	sequence s_weak_held;
		charge_state_out == CTL_ST_WEAK ##1 charge_state_out == CTL_ST_WEAK;
	endsequence
	sequence s_trickle_fault;
		charge_state_out == CTL_ST_TRICKLE ##1 charge_state_out == CTL_ST_FAULT;
	endsequence
	AST_BUS_OKAY: assert property (hreadyout_out && !hresp_out)
		else $error("bus answer not ready or not okay");
	AST_RST_LIMIT: assert property ($fell(rst_in)
		&& !(pin_role_in && limit_select_pin_in) |-> ##2 drive_out.limit_ma == 12'h064)
		else $error("limit after reset not 100 mA");
	AST_TRICKLE_DRIVE: assert property (charge_state_out == CTL_ST_TRICKLE
		|-> drive_out.trickle_on && !drive_out.iso_fet_on && drive_out.sys_at_trickle)
		else $error("trickle drive wrong");
	AST_WEAK_DRIVE: assert property (s_weak_held
		|-> drive_out.limit_ma == 12'h064
		&& drive_out.current_ma == CTL_WEAK_MA && drive_out.sys_at_charge)
		else $error("weak drive wrong");
	AST_OFF_DRIVE: assert property ((charge_state_out == CTL_ST_OFF)
		|| (charge_state_out == CTL_ST_FAULT) |-> !drive_out.trickle_on && !drive_out.fast_on)
		else $error("charging branch on while stopped");
	AST_TO_WEAK: assert property (charge_state_out == CTL_ST_TRICKLE && supply_ok_in
		&& above_dead_in && !above_weak_in |=> charge_state_out == CTL_ST_WEAK)
		else $error("no weak entry");
	AST_TO_FAST: assert property (charge_state_out == CTL_ST_WEAK && supply_ok_in
		&& above_weak_in |=> charge_state_out == CTL_ST_FAST && drive_out.fast_on)
		else $error("no fast entry");
	AST_FAULT_LATE: assert property (cnt_q <= LIM + 3)
		else $error("trickle ran past its limit");
	AST_FAULT_EARLY: assert property (s_trickle_fault |-> cnt_q + 3 >= LIM)
		else $error("trickle fault too early");
endmodule
bind chgctl_top chgctl_props #(.CLK_HZ(CLK_HZ), .TRICKLE_SEC(TRICKLE_SEC)) u_props (
	.clk_in(clk_in), .rst_in(rst_in), .hreadyout_out(hreadyout_out),
	.hresp_out(hresp_out), .limit_select_pin_in(limit_select_pin_in),
	.pin_role_in(pin_role_in), .supply_ok_in(supply_ok_in), .above_dead_in(above_dead_in),
	.above_weak_in(above_weak_in), .drive_out(drive_out), .charge_state_out(charge_state_out));

/* sim/chgctl_batt_model.sv */
// Cell comparators and input limiter seen by the charger
module chgctl_batt_model (
	// Clock and scenario level
	input  wire logic        clk_in,
	input  wire logic [1:0]  level_in,
	// Charger drive seen
	input  wire logic [11:0] limit_ma_in,
	input  wire logic [11:0] current_ma_in,
	// Comparator and limiter levels
	output logic             above_dead_out = 1'b0,
	output logic             above_weak_out = 1'b0,
	output logic             limit_active_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Level 0 dead cell, 1 weak cell, 2 healthy cell
	always_ff @(posedge clk_in) begin
		above_dead_out <= (level_in != 2'h0);
		above_weak_out <= (level_in == 2'h2);
	end
	// Limiter regulates when the supply cap is below the charge target
	always_ff @(posedge clk_in) begin
		limit_active_out <= (limit_ma_in < current_ma_in);
	end
endmodule

/* sim/chgctl_top_test.sv */
// Self-checking bench for the charger control block
module chgctl_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import chgctl_pkg::*;
	// ==========================================================
	// Signals and rows
	// ==========================================================
	logic             clk_in = 1'b0;
	logic             rst_in = 1'b1;
	logic             hsel = 1'b0, hwrite = 1'b0, pin = 1'b0, role = 1'b0;
	logic [1:0]       htrans = 2'h0, lvl = 2'h2;
	logic [31:0]      haddr = 32'h0, hwdata = 32'h0, hrdata_out, r;
	logic             hreadyout_out, hresp_out, ad, aw, la, flag;
	chgctl_drive_type drv;
	logic [2:0]       st;
	int               n_errors = 0, checks = 0, cyc = 0;
	logic [3:0]  code [7] = '{4'h2, 4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7};
	logic [11:0] ma [7] = '{12'h12c, 12'h064, 12'h096, 12'h1f4, 12'h384, 12'h5dc, 12'h5dc};
	logic        fl [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
	// Short counts so the trickle fault comes after 30 cycles
	chgctl_top #(.CLK_HZ(10), .TRICKLE_SEC(3)) u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hreadyout_out),
		.hwdata_in(hwdata), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out), .limit_select_pin_in(pin), .pin_role_in(role),
		.supply_ok_in(1'b1), .above_dead_in(ad), .above_weak_in(aw), .limit_active_in(la),
		.drive_out(drv), .charge_state_out(st), .input_limited_flag_out(flag));
	chgctl_batt_model u_batt (.clk_in(clk_in), .level_in(lvl), .limit_ma_in(drv.limit_ma),
		.current_ma_in(drv.current_ma), .above_dead_out(ad), .above_weak_out(aw),
		.limit_active_out(la));
	// Clock and hang guard
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			close_out();
		end
	end
	// ==========================================================
	// Tasks
	// ==========================================================
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// One AHB-Lite single transfer, launched on an edge, waits on hready in both phases
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk_in);
		while (hreadyout_out !== 1'b1) @(posedge clk_in);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_in);
		while (hreadyout_out !== 1'b1) @(posedge clk_in);
		r = hrdata_out;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask
	task wt();
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	function logic [31:0] stat(logic [11:0] m, logic f, logic [2:0] s);
		return {4'h0, m, 11'h0, f, 1'b0, s};
	endfunction
	task close_out();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		wt();
		rdchk(8'h08, 32'h0fff0007, stat(12'h064, 1'b0, CTL_ST_FAST));
		rdchk(8'h04, 32'hffffffff, 32'h01f40001);
		bus(1'b1, 8'h10, 32'hffffffff);
		rdchk(8'h10, 32'hffffffff, 32'h0);
		rdchk(8'h00, 32'hffffffff, 32'h0);
		role <= 1'b1;
		pin <= 1'b1;
		wt();
		rdchk(8'h08, 32'h0fff0000, stat(12'h1f4, 1'b0, 3'h0));
		pin <= 1'b0;
		wt();
		rdchk(8'h08, 32'h0fff0000, stat(12'h064, 1'b0, 3'h0));
		pin <= 1'b1;
		$display("reset and pin test done");
		// Limit codes with the select pin high, flag against 500 mA target
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, 8'h00, {28'h0, code[i]});
			wt();
			rdchk(8'h08, 32'h0fff0017, stat(ma[i], fl[i], CTL_ST_FAST));
			chk(flag, fl[i]);
		end
		$display("limit table done");
		// Trickle, weak, trickle again with timer restart, then fault
		lvl <= 2'h0;
		wt();
		chk(st, CTL_ST_TRICKLE);
		chk({drv.iso_fet_on, drv.sys_at_trickle}, 2'b01);
		repeat (15) @(posedge clk_in);
		lvl <= 2'h1;
		wt();
		chk(st, CTL_ST_WEAK);
		chk(drv.limit_ma, 12'h064);
		chk({drv.trickle_on, drv.current_ma}, {1'b1, CTL_WEAK_MA});
		chk(drv.sys_at_charge, 1'b1);
		@(posedge clk_in);
		lvl <= 2'h0;
		repeat (20) @(posedge clk_in);
		#1;
		chk(st, CTL_ST_TRICKLE);
		repeat (15) @(posedge clk_in);
		#1;
		chk({st, drv.trickle_on}, {CTL_ST_FAULT, 1'b0});
		bus(1'b1, 8'h04, 32'h01f40000);
		lvl <= 2'h2;
		wt();
		chk({st, drv.trickle_on, drv.fast_on}, {CTL_ST_OFF, 2'b00});
		bus(1'b1, 8'h04, 32'h01f40001);
		wt();
		chk({st, drv.fast_on}, {CTL_ST_FAST, 1'b1});
		// Straight from fast down to weak, then back up to fast
		@(posedge clk_in);
		lvl <= 2'h1;
		wt();
		chk({st, drv.limit_ma}, {CTL_ST_WEAK, 12'h064});
		@(posedge clk_in);
		lvl <= 2'h2;
		wt();
		chk({st, drv.limit_ma}, {CTL_ST_FAST, 12'h5dc});
		$display("mode test done");
		// Second reset in mid-run drops the changed field
		@(posedge clk_in);
		pin <= 1'b0;
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		wt();
		rdchk(8'h08, 32'h0fff0000, stat(12'h064, 1'b0, 3'h0));
		rdchk(8'h00, 32'hffffffff, 32'h0);
		$display("second reset done");
		close_out();
	end
endmodule
